// [rtl/alarm_supervisor.sv]
// Behaviour
// - Any alarm but external stop: coast, release hold, show code.
// - Overcurrent, store error cleared only by power.
// - External stop brakes, releases hold once stopped.
// - Each alarm reports its own code.
// - Excess driver current raises overcurrent.
// - Overtemperature raises main circuit overheat.
// - Supply above 120 percent raises overvoltage.
// - Supply below 60 percent raises undervoltage.
// - Speed above 4800 r/min raises overspeed.
// - Overload longer than set time raises overload.
// - Limited duty overload alarms within 5 s.
// - Cold motor start raises overload.
// - Open sensor at power-up raises alarm.
// - Corrupt or dead store raises store alarm.
// - Panel mode: run switch at power-up alarms.
// - External mode: run input at power-up alarms.
// - Power-on prevention only when enabled.
// - Outside fault input low raises external stop.
// - Resettable alarms clear by panel or input.
// - Warnings appear before their alarms.
// - Fault-clear acts on its falling edge.
// - Fault-clear ignored while run signal active.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module alarm_supervisor
   import alarm_pkg::*;
#(
   parameter longint OVL_MAX_CYCLES = OVL_MAX_CYC
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Register bus, AXI4-Lite.
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Fault detections, asynchronous.
   input wire logic overCurrentDet,
   input wire logic overTempAlarmDet,
   input wire logic overTempWarnDet,
   input wire logic overVoltDet,
   input wire logic underVoltDet,
   input wire logic overSpeedDet,
   input wire logic contOverloadDet,
   input wire logic limitedOverloadDet,
   input wire logic shaftLockDet,
   input wire logic overloadWarnDet,
   input wire logic coldStartDet,
   input wire logic sensorOpenDet,
   input wire logic storeFaultDet,
   input wire logic motorStoppedDet,
   // Operator inputs, asynchronous.
   input wire logic panelRunSwitch,
   input wire logic forward_run_input,
   input wire logic backward_run_input,
   input wire logic outside_fault_input,
   input wire logic faultClearInput,
   // Motor control outputs.
   output logic driveEnable,
   output logic brakeNow,
   output logic holdPower,
   output logic [7:0] alarmCode,
   output logic alarmActive,
   output logic warning
);

   // Synchroniser for every asynchronous input.
   localparam int NIN = 19;
   logic [NIN-1:0] rawIn; // Pins as they arrive.
   logic [NIN-1:0] syncA; // First stage, read only by the second.
   logic [NIN-1:0] syncB; // Clean, usable levels.

   assign rawIn = {overCurrentDet, overTempAlarmDet, overTempWarnDet,
      overVoltDet, underVoltDet, overSpeedDet, contOverloadDet,
      limitedOverloadDet, shaftLockDet, overloadWarnDet, coldStartDet,
      sensorOpenDet, storeFaultDet, motorStoppedDet, panelRunSwitch,
      forward_run_input, backward_run_input, outside_fault_input,
      faultClearInput};

   // Two flip-flops per input before any logic looks at it.
   generate
      for (genvar g = 0; g < NIN; g++) begin : gSync
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               syncA[g] <= 1'b0;
               syncB[g] <= 1'b0;
            end else begin
               syncA[g] <= rawIn[g];
               syncB[g] <= syncA[g];
            end
         end
      end
   endgenerate

   // Named views of the synchronised levels.
   logic sOverCur, sTempA, sTempW, sOverV, sUnderV, sOverSpd;
   logic sContOvl, sLimOvl, sLock, sOvlWarn, sCold, sSensor, sStore;
   logic sStopped, sPanelRun, sFwd, sBwd, sOutside, sClear;
   assign {sOverCur, sTempA, sTempW, sOverV, sUnderV, sOverSpd, sContOvl,
      sLimOvl, sLock, sOvlWarn, sCold, sSensor, sStore, sStopped,
      sPanelRun, sFwd, sBwd, sOutside, sClear} = syncB;

   // Register file.
   logic [5:0] ctrlReg; // Control bits.
   logic [31:0] ovlTimeReg; // Overload detection time in cycles.
   logic panelResetPulse; // Monitor-mode reset command.
   logic [31:0] statusWord; // Read-back of the block state.
   runmode_type runMode; // External run-signal setting.

   assign runMode = runmode_type'(ctrlReg[RUNMODE_LSB +: 2]);

   alarm_axil uBus (
      .mclk,
      .rst_n,
      .awaddr,
      .awvalid,
      .awready,
      .wdata,
      .wstrb,
      .wvalid,
      .wready,
      .bresp,
      .bvalid,
      .bready,
      .araddr,
      .arvalid,
      .arready,
      .rdata,
      .rresp,
      .rvalid,
      .rready,
      .ctrlReg,
      .ovlTimeReg,
      .panelResetPulse,
      .statusWord
   );

   // Run request active on the source selected by runMode.
   logic runActive;
   assign runActive = (runMode == RUN_PANEL) ? sPanelRun : (sFwd || sBwd);

   // Power-on checks wait two edges after reset,
   // because the synchronisers need them to fill.
   logic [1:0] startCnt_reg; // Counts settle cycles after reset.
   logic powerUpCheck; // One cycle, inputs valid.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         startCnt_reg <= 2'd0;
      end else if (startCnt_reg != 2'd3) begin
         startCnt_reg <= startCnt_reg + 2'd1;
      end
   end
   assign powerUpCheck = (startCnt_reg == 2'd2);

   // Overload timer; limited duty or lock
   // caps the set time at five seconds.
   logic [31:0] ovlCnt_reg; // Cycles of overload so far.
   logic [31:0] ovlLimit; // Effective limit this cycle.
   logic ovlTrip; // Overload time exceeded.
   localparam logic [31:0] OVL_CAP = 32'(OVL_MAX_CYCLES);
   always_comb begin
      ovlLimit = ovlTimeReg;
      if ((sLimOvl || sLock) && ovlTimeReg > OVL_CAP) begin
         ovlLimit = OVL_CAP;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ovlCnt_reg <= 32'h0;
      end else if (sContOvl || sLimOvl || sLock) begin
         if (ovlCnt_reg != 32'hffffffff) begin
            ovlCnt_reg <= ovlCnt_reg + 32'h1;
         end
      end else begin
         ovlCnt_reg <= 32'h0;
      end
   end
   // A zero set time must not trip while no overload is present.
   assign ovlTrip = (sContOvl || sLimOvl || sLock)
      && (ovlCnt_reg >= ovlLimit);

   // Fault-clear acts on its falling edge
   // after a 10 ms hold with no run.
   logic clearPrev_reg; // Last sampled fault-clear level.
   logic [31:0] clearCnt_reg; // How long fault-clear has been high.
   logic clearVetoed_reg; // A run signal was seen during the hold.
   logic clearReq; // Valid reset request this cycle.
   localparam logic [31:0] FCLR_CYC = 32'(FCLR_MIN_CYC);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clearPrev_reg <= 1'b0;
         clearCnt_reg <= 32'h0;
         clearVetoed_reg <= 1'b0;
      end else begin
         clearPrev_reg <= sClear;
         if (!sClear) begin
            clearCnt_reg <= 32'h0;
            clearVetoed_reg <= 1'b0;
         end else begin
            if (clearCnt_reg != 32'hffffffff) begin
               clearCnt_reg <= clearCnt_reg + 32'h1;
            end
            if (runActive) begin
               clearVetoed_reg <= 1'b1;
            end
         end
      end
   end
   assign clearReq = (ctrlReg[FCLR_EN_BIT] && clearPrev_reg && !sClear
      && !clearVetoed_reg && !runActive
      && clearCnt_reg >= FCLR_CYC)
      || (panelResetPulse && !runActive);

   // Priority: the first active source names the alarm.
   logic [7:0] newCode; // Code of a new alarm, or none.
   always_comb begin
      newCode = CODE_NONE;
      if (sOverCur) begin
         newCode = CODE_OVERCURRENT;
      end else if (sStore) begin
         newCode = CODE_STORE;
      end else if (sOverV) begin
         newCode = CODE_OVERVOLT;
      end else if (sUnderV) begin
         newCode = CODE_UNDERVOLT;
      end else if (sTempA) begin
         newCode = CODE_OVERHEAT;
      end else if (sOverSpd) begin
         newCode = CODE_OVERSPEED;
      end else if (ovlTrip || (sCold && runActive)) begin
         newCode = CODE_OVERLOAD;
      end else if (sSensor && powerUpCheck) begin
         newCode = CODE_SENSOR_PWRON;
      end else if (sSensor && startCnt_reg == 2'd3) begin
         newCode = CODE_SENSOR;
      end else if (ctrlReg[EXTSTOP_EN_BIT] && !sOutside
         && startCnt_reg == 2'd3) begin
         newCode = CODE_EXT_STOP;
      end else if (ctrlReg[PREVENT_EN_BIT] && powerUpCheck
         && runActive) begin
         newCode = CODE_PWRON_PREVENT;
      end
   end

   // Latch: held until a permitted clear.
   logic alarmLatched; // An alarm is stored.
   logic powerOnly; // The stored alarm needs a power cycle.
   assign alarmLatched = (alarmCode != CODE_NONE);
   assign powerOnly = (alarmCode == CODE_OVERCURRENT)
      || (alarmCode == CODE_STORE);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         alarmCode <= CODE_NONE;
         alarmActive <= 1'b0;
      end else if (!alarmLatched) begin
         alarmCode <= newCode;
         alarmActive <= (newCode != CODE_NONE);
      end else if (alarmCode == CODE_PWRON_PREVENT && !runActive) begin
         // Prevention clears once run drops.
         alarmCode <= CODE_NONE;
         alarmActive <= 1'b0;
      end else if (clearReq && !powerOnly) begin
         alarmCode <= CODE_NONE;
         alarmActive <= 1'b0;
      end
   end

   // Stop sequence: coast or brake, then drop holding power.
   stop_type stop_reg;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stop_reg <= ST_RUN;
      end else begin
         unique case (stop_reg)
            ST_RUN: begin
               if (newCode == CODE_EXT_STOP && !alarmLatched) begin
                  stop_reg <= ST_BRAKE;
               end else if (newCode != CODE_NONE && !alarmLatched) begin
                  stop_reg <= ST_COAST;
               end
            end
            ST_BRAKE: begin
               if (sStopped) begin
                  stop_reg <= ST_RELEASED;
               end
            end
            ST_COAST: stop_reg <= ST_RELEASED;
            ST_RELEASED: begin
               if (!alarmLatched) begin
                  stop_reg <= ST_RUN;
               end
            end
         endcase
      end
   end

   // Motor outputs, registered.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         driveEnable <= 1'b0;
         brakeNow <= 1'b0;
         holdPower <= 1'b0;
      end else begin
         driveEnable <= (stop_reg == ST_RUN) && !alarmLatched
            && (newCode == CODE_NONE) && runActive;
         brakeNow <= (stop_reg == ST_BRAKE);
         holdPower <= (stop_reg == ST_RUN) || (stop_reg == ST_BRAKE);
      end
   end

   // Warnings use lower thresholds than alarms.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         warning <= 1'b0;
      end else begin
         warning <= sTempW || sOvlWarn
            || (ovlCnt_reg != 32'h0 && !ovlTrip);
      end
   end

   assign statusWord = {16'h0, 2'b00, stop_reg == ST_BRAKE,
      stop_reg == ST_RUN, warning, powerOnly, alarmActive, driveEnable,
      alarmCode};

endmodule
`default_nettype wire

// [rtl/alarm_pkg.sv]
package alarm_pkg;

   // Alarm codes shown while an alarm is latched.
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_OVERCURRENT = 8'h20;
   localparam logic [7:0] CODE_OVERHEAT = 8'h21;
   localparam logic [7:0] CODE_OVERVOLT = 8'h22;
   localparam logic [7:0] CODE_UNDERVOLT = 8'h25;
   localparam logic [7:0] CODE_SENSOR = 8'h28;
   localparam logic [7:0] CODE_OVERLOAD = 8'h30;
   localparam logic [7:0] CODE_OVERSPEED = 8'h31;
   localparam logic [7:0] CODE_STORE = 8'h41;
   localparam logic [7:0] CODE_SENSOR_PWRON = 8'h42;
   localparam logic [7:0] CODE_PWRON_PREVENT = 8'h46;
   localparam logic [7:0] CODE_EXT_STOP = 8'h6e;

   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] OVLTIME_OFFSET = 8'h08;

   // Control register field positions.
   localparam int RUNMODE_LSB = 0;
   localparam int PREVENT_EN_BIT = 2;
   localparam int EXTSTOP_EN_BIT = 3;
   localparam int FCLR_EN_BIT = 4;
   localparam int PANEL_RESET_BIT = 5;

   // Control reset: panel run, prevention enabled.
   localparam logic [5:0] CTRL_RESET = 6'h04;

   // Timing, the clock runs at 100 MHz.
   localparam longint CLK_HZ = 100000000;
   localparam longint OVL_MAX_S = 5;
   localparam longint OVL_MAX_CYC = OVL_MAX_S * CLK_HZ;
   localparam longint FCLR_MIN_MS = 10;
   localparam longint FCLR_MIN_CYC = FCLR_MIN_MS * CLK_HZ / 1000;
   localparam longint PWROFF_MIN_S = 60;
   localparam logic [31:0] OVLTIME_RESET = 32'h1dcd6500;

   // Run-signal source selection.
   typedef enum logic [1:0] {
      RUN_PANEL,
      RUN_LEVEL,
      RUN_EDGE
   } runmode_type;

   // Motor stop handling.
   typedef enum {
      ST_RUN,
      ST_COAST,
      ST_BRAKE,
      ST_RELEASED
   } stop_type;

endpackage

// [rtl/alarm_axil.sv]
`timescale 1ns/10ps
`default_nettype none
// AXI4-Lite slave for the block's registers.
module alarm_axil
   import alarm_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Write channels.
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read channels.
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register contents and status.
   output logic [5:0] ctrlReg,
   output logic [31:0] ovlTimeReg,
   output logic panelResetPulse,
   input wire logic [31:0] statusWord
);

   logic [7:0] awAddrReg; // Captured write address.
   logic awHeld; // Write address taken, waiting for data.
   logic [31:0] wDataReg; // Captured write data.
   logic [3:0] wStrbReg; // Captured strobes.
   logic wHeld; // Write data taken.
   logic doWrite; // Both halves present, no response pending.

   assign doWrite = awHeld && wHeld && !bvalid;
   assign awready = !awHeld;
   assign wready = !wHeld;
   assign arready = !rvalid;

   // Address and data are taken independently, in either order.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrReg <= 8'h00;
         wDataReg <= 32'h0;
         wStrbReg <= 4'h0;
      end else begin
         if (awvalid && !awHeld) begin
            awHeld <= 1'b1;
            awAddrReg <= awaddr;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
         if (wvalid && !wHeld) begin
            wHeld <= 1'b1;
            wDataReg <= wdata;
            wStrbReg <= wstrb;
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   // Register writes; unmapped addresses give SLVERR.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrlReg <= CTRL_RESET;
         ovlTimeReg <= OVLTIME_RESET;
         panelResetPulse <= 1'b0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end else begin
         panelResetPulse <= 1'b0;
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= 2'b00;
            if (awAddrReg == CTRL_OFFSET) begin
               if (wStrbReg[0]) begin
                  // The panel reset bit is a self-clearing command.
                  ctrlReg <= {1'b0, wDataReg[4:0]};
                  panelResetPulse <= wDataReg[PANEL_RESET_BIT];
               end
            end else if (awAddrReg == OVLTIME_OFFSET) begin
               for (int i = 0; i < 4; i++) begin
                  if (wStrbReg[i]) begin
                     ovlTimeReg[i*8 +: 8] <= wDataReg[i*8 +: 8];
                  end
               end
            end else if (awAddrReg != STATUS_OFFSET) begin
               bresp <= 2'b10;
            end
         end
      end
   end

   // Read path: one cycle after the address is taken.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= 2'b00;
      end else if (arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rresp <= 2'b00;
         unique case (araddr)
            CTRL_OFFSET: rdata <= {26'h0, ctrlReg};
            STATUS_OFFSET: rdata <= statusWord;
            OVLTIME_OFFSET: rdata <= ovlTimeReg;
            default: begin
               rdata <= 32'h0;
               rresp <= 2'b10;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [sim/alarm_supervisor_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// Checks the supervisor's protection at its pins.
module alarm_supervisor_sva
   import alarm_pkg::*;
#(
   parameter longint OVL_MAX_CYCLES = OVL_MAX_CYC
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Inputs of interest.
   input wire logic overCurrentDet,
   input wire logic overTempWarnDet,
   input wire logic limitedOverloadDet,
   input wire logic panelRunSwitch,
   input wire logic forward_run_input,
   input wire logic backward_run_input,
   input wire logic faultClearInput,
   input wire logic awvalid,
   // Motor outputs.
   input wire logic driveEnable,
   input wire logic brakeNow,
   input wire logic holdPower,
   input wire logic [7:0] alarmCode,
   input wire logic alarmActive,
   input wire logic warning
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Any run request on any of the three sources.
   logic runAny;
   // Limited duty overload cycles without alarm.
   logic [31:0] ovlCnt;
   assign runAny = panelRunSwitch | forward_run_input | backward_run_input;
   // Counts only while running, though the supervisor also trips on an idle flag.
   always_ff @(posedge mclk) begin
      if (!rst_n || alarmActive || !limitedOverloadDet || !runAny) begin
         ovlCnt <= 32'h0;
      end else begin
         ovlCnt <= ovlCnt + 32'h1;
      end
   end
   a_drive_blocked: assert property (alarmActive |-> !driveEnable)
      else $error("Drive while latched");
   a_overcur_code: assert property ($rose(overCurrentDet) &&
      !alarmActive |-> ##3 alarmCode == CODE_OVERCURRENT)
      else $error("Overcurrent code wrong");
   a_power_only: assert property (alarmCode == CODE_OVERCURRENT ||
      alarmCode == CODE_STORE |=> $stable(alarmCode))
      else $error("Power-only alarm cleared");
   a_coast_stop: assert property ($rose(alarmActive) &&
      alarmCode != CODE_EXT_STOP |-> !brakeNow ##2 !holdPower)
      else $error("No coast stop");
   a_ext_brake: assert property (
      $rose(alarmCode == CODE_EXT_STOP) |=> brakeNow && !driveEnable)
      else $error("No brake");
   a_code_latch: assert property (
      alarmActive |=> !alarmActive || $stable(alarmCode))
      else $error("Latched code changed");
   a_run_blocks: assert property (
      runAny [*6] ##0 (alarmActive && alarmCode != CODE_PWRON_PREVENT)
      |=> alarmActive) else $error("Cleared while running");
   a_rise_noclear: assert property ($rose(faultClearInput) &&
      alarmActive && !awvalid |-> alarmActive [*4])
      else $error("Cleared on rising edge");
   a_warn_first: assert property ($rose(overTempWarnDet) &&
      !alarmActive |-> ##3 warning) else $error("Warning missing");
   a_ovl_cap: assert property (ovlCnt <= OVL_MAX_CYCLES + 8)
      else $error("Overload alarm late");
   // Main scenarios reached.
   c_ext: cover property (alarmCode == CODE_EXT_STOP && brakeNow);
   c_ovl: cover property (alarmCode == CODE_OVERLOAD);
   c_warn: cover property (warning && !alarmActive);
endmodule
`default_nettype wire

// [sim/motor_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Shaft model: braking stops it four times faster.
module motor_model #(
   parameter int STOP_CYCLES = 40
)
(
   // Clock.
   input wire logic mclk,
   // Commands from the supervisor.
   input wire logic driveEnable,
   input wire logic brakeNow,
   // Shaft at rest.
   output logic motorStoppedDet
);
   // Wind-down progress; the shaft starts at rest.
   int spinDown = STOP_CYCLES;
   // Driving spins the shaft up at once.
   always_ff @(posedge mclk) begin
      if (driveEnable) begin
         spinDown <= 0;
      end else if (spinDown < STOP_CYCLES) begin
         spinDown <= spinDown + (brakeNow ? 4 : 1);
      end
   end
   assign motorStoppedDet = (spinDown >= STOP_CYCLES);
endmodule
`default_nettype wire

// [sim/test_alarm_supervisor.sv]
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench: bus tasks plus fault sequences.
module test_alarm_supervisor;
   import alarm_pkg::*;
   // Short cap keeps overload cases quick.
   localparam longint OVL_CAP = 200;
   localparam int N_CASE = 8;
   // Pin index and code of each single fault.
   localparam int IDX [N_CASE] = '{0, 12, 1, 3, 4, 5, 11, 10};
   localparam logic [7:0] CODES [N_CASE] = '{CODE_OVERCURRENT,
      CODE_STORE, CODE_OVERHEAT, CODE_OVERVOLT, CODE_UNDERVOLT,
      CODE_OVERSPEED, CODE_SENSOR, CODE_OVERLOAD};
   logic mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [12:0] det = 13'h0;
   logic panelRunSwitch = 1'b0, faultClearInput = 1'b0;
   logic forward_run_input = 1'b0, backward_run_input = 1'b0;
   logic outside_fault_input = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, motorStoppedDet;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic driveEnable, brakeNow, holdPower, alarmActive, warning;
   logic [7:0] alarmCode;
   int n_mismatch = 0;
   int comparisons = 0;

   always #5 mclk = ~mclk;

   alarm_supervisor #(.OVL_MAX_CYCLES(OVL_CAP)) DUT (.mclk, .rst_n,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .overCurrentDet(det[0]),
      .overTempAlarmDet(det[1]), .overTempWarnDet(det[2]),
      .overVoltDet(det[3]), .underVoltDet(det[4]), .overSpeedDet(det[5]),
      .contOverloadDet(det[6]), .limitedOverloadDet(det[7]),
      .shaftLockDet(det[8]), .overloadWarnDet(det[9]),
      .coldStartDet(det[10]), .sensorOpenDet(det[11]),
      .storeFaultDet(det[12]), .motorStoppedDet, .panelRunSwitch,
      .forward_run_input, .backward_run_input, .outside_fault_input,
      .faultClearInput, .driveEnable, .brakeNow, .holdPower, .alarmCode,
      .alarmActive, .warning);

   motor_model #(.STOP_CYCLES(40)) motor (.mclk, .driveEnable, .brakeNow,
      .motorStoppedDet);

   // Counts a comparison, reports a mismatch.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints counts and verdict, then ends.
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Waits n edges, then settles before sampling.
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // A power cycle as the supervisor sees it.
   task automatic powerUp();
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      tick(6);
   endtask

   // Bus write; each channel is released when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int i;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      check(32'(bresp), 32'h0);
      if (i == 20) begin
         n_mismatch++;
         summarize();
      end
   endtask

   // Bus read, checked against data and response.
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      int i;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      check(rdata, d);
      check(32'(rresp), 32'(r));
      if (i == 20) begin
         n_mismatch++;
         summarize();
      end
   endtask

   initial begin
      powerUp();
      rd(CTRL_OFFSET, 32'h4, 2'b00);
      rd(OVLTIME_OFFSET, OVLTIME_RESET, 2'b00);
      rd(8'h0c, 32'h0, 2'b10);
      wr(OVLTIME_OFFSET, 32'h32, 4'h1);
      rd(OVLTIME_OFFSET, 32'h1dcd6532, 2'b00);
      $display("Test registers done");
      // Each fault latches its code; panel reset clears some.
      for (int k = 0; k < N_CASE; k++) begin
         powerUp();
         @(posedge mclk);
         panelRunSwitch <= (k == 7);
         det[IDX[k]] <= 1'b1;
         tick(4);
         check(32'(alarmCode), 32'(CODES[k]));
         check(32'(driveEnable), 32'h0);
         tick(2);
         check(32'({brakeNow, holdPower}), 32'h0);
         @(posedge mclk);
         det <= 13'h0;
         panelRunSwitch <= 1'b0;
         tick(6);
         check(32'(alarmCode), 32'(CODES[k]));
         wr(CTRL_OFFSET, 32'h24, 4'h1);
         tick(6);
         check(32'(alarmCode), (k < 2) ? 32'(CODES[k]) : 32'h0);
      end
      $display("Test fault codes done");
      // Open sensor, then run switch, already on at power-up.
      det[11] <= 1'b1;
      powerUp();
      check(32'(alarmCode), 32'(CODE_SENSOR_PWRON));
      det <= 13'h0;
      panelRunSwitch <= 1'b1;
      powerUp();
      check(32'(alarmCode), 32'(CODE_PWRON_PREVENT));
      panelRunSwitch <= 1'b0;
      tick(6);
      check(32'(alarmCode), 32'h0);
      $display("Test power-on done");
      // External stop in edge mode while the shaft turns.
      wr(CTRL_OFFSET, 32'h0e, 4'h1);
      forward_run_input <= 1'b1;
      tick(6);
      check(32'(driveEnable), 32'h1);
      outside_fault_input <= 1'b0;
      tick(4);
      check(32'({alarmCode, brakeNow, holdPower}), 32'h1bb);
      tick(20);
      check(32'(holdPower), 32'h0);
      // Panel reset with run held is refused; the fault-clear pulse is short and not enabled.
      faultClearInput <= 1'b1;
      outside_fault_input <= 1'b1;
      tick(8);
      faultClearInput <= 1'b0;
      wr(CTRL_OFFSET, 32'h2e, 4'h1);
      tick(6);
      check(32'(alarmCode), 32'(CODE_EXT_STOP));
      check(32'(driveEnable), 32'h0);
      forward_run_input <= 1'b0;
      tick(4);
      wr(CTRL_OFFSET, 32'h2e, 4'h1);
      tick(6);
      check(32'(alarmCode), 32'h0);
      $display("Test external stop done");
      // Timed overload and heat warn, then overload alarms.
      powerUp();
      wr(OVLTIME_OFFSET, 32'h32, 4'hf);
      panelRunSwitch <= 1'b1;
      det <= 13'h44;
      tick(30);
      check(32'({alarmCode, warning}), 32'h1);
      tick(40);
      check(32'(alarmCode), 32'(CODE_OVERLOAD));
      // Limited duty and lock are capped.
      for (int j = 7; j < 9; j++) begin
         panelRunSwitch <= 1'b0;
         det <= 13'h0;
         powerUp();
         panelRunSwitch <= 1'b1;
         det[j] <= 1'b1;
         tick(int'(OVL_CAP) + 20);
         check(32'(alarmCode), 32'(CODE_OVERLOAD));
      end
      $display("Test overload done");
      summarize();
   end
endmodule

bind alarm_supervisor alarm_supervisor_sva #(
   .OVL_MAX_CYCLES(OVL_MAX_CYCLES)
) chk (.mclk, .rst_n, .overCurrentDet, .overTempWarnDet,
   .limitedOverloadDet, .panelRunSwitch, .forward_run_input,
   .backward_run_input, .faultClearInput, .awvalid, .driveEnable,
   .brakeNow, .holdPower, .alarmCode, .alarmActive, .warning);
`default_nettype wire
